// ### acs_pkg.sv
// Constants shared by the converter control block and its helpers.
// Assumes a 100 MHz system clock; the serial link is sampled by it.
package acs_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int SYS_CLK_MHZ     = 100;
   // Internal conversion clock period, in nanoseconds.
   localparam int INT_CONV_CLK_NS = 500;
   localparam int INT_TICK_CYC    = (INT_CONV_CLK_NS * SYS_CLK_MHZ + 999) / 1000;

   // ****************************************************************
   // Control byte fields
   // ****************************************************************
   localparam int BYTE_BITS   = 8;
   localparam int BIT_START   = 7;
   localparam int BIT_CODE_H  = 6;
   localparam int BIT_CODE_M  = 5;
   localparam int BIT_CODE_L  = 4;
   localparam int BIT_CONFIG  = 3;
   localparam int BIT_RANGE   = 2;
   localparam int BIT_MODE_H  = 1;
   localparam int BIT_MODE_L  = 0;

   // ****************************************************************
   // Falling-edge positions counted from the start bit
   // ****************************************************************
   localparam logic [4:0] FALL_MUX      = 5'h05;
   localparam logic [4:0] FALL_HOLD     = 5'h08;
   localparam logic [4:0] FALL_MSB      = 5'h0a;
   localparam int         RES_BITS      = 14;
   localparam int         CONV_TICKS    = 15;
   localparam logic [4:0] EXT_CONV_FALLS = 5'h12;
   localparam logic [4:0] FALL_DONE     = FALL_MUX + EXT_CONV_FALLS;
   localparam logic [3:0] INT_READ_FALLS = 4'hf;

   // ****************************************************************
   // Modes, states and reset values
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_PD_FULL = 2'h0,
      MODE_PD_FAST = 2'h1,
      MODE_INT_CLK = 2'h2,
      MODE_EXT_CLK = 2'h3
   } acs_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'h0,
      ST_RECEIVE  = 2'h1,
      ST_EXT_CONV = 2'h3,
      ST_INT_CONV = 2'h2
   } acs_state_t;

   localparam acs_mode_t  MODE_RST   = MODE_INT_CLK;
   localparam logic       STRB_RST   = 1'h1;
   localparam int         FIFO_DEPTH = 8;

endpackage

// ### acs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
module acs_fifo
   import acs_pkg::*;
#(
   parameter int WIDTH = 14,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   // Write side
   input  wire logic             wr_valid_i,
   output      logic             wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // Read side
   output      logic             rd_valid_o,
   input  wire logic             rd_ready_i,
   output      logic [WIDTH-1:0] rd_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             do_wr;
   logic             do_rd;

   assign wr_ready_o = (count != (AW+1)'(DEPTH));
   assign rd_valid_o = (count != '0);
   assign do_wr      = wr_valid_i & wr_ready_o;
   assign do_rd      = rd_valid_o & rd_ready_i;
   assign rd_data_o  = mem[rd_ptr];

   always_ff @(posedge sys_clk_i) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

endmodule

// ### acs_sar.sv
// Successive-approximation register: one step per conversion tick.
// Assumes a synchronised comparator level and single-cycle ticks.
module acs_sar
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                arst_n_i,
   // Control
   input  wire logic                start_i,
   input  wire logic                abort_i,
   input  wire logic                tick_i,
   input  wire logic                comp_i,
   // Trial code to the capacitive DAC
   output      logic [RES_BITS-1:0] dac_code_o,
   // Finished word, held until taken
   output      logic                res_valid_o,
   input  wire logic                res_ready_i,
   output      logic [RES_BITS-1:0] res_data_o
);

   logic                busy;
   logic [3:0]          step;
   logic [RES_BITS-1:0] next_code;

   // Keep or drop the bit under trial, then try the next lower bit.
   always_comb begin
      next_code = dac_code_o;
      for (int i = 0; i < RES_BITS; i++) begin
         if (step == 4'(RES_BITS - i)) begin
            next_code[i] = comp_i;
            if (i > 0) begin
               next_code[i-1] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy        <= 1'b0;
         step        <= '0;
         dac_code_o  <= '0;
         res_valid_o <= 1'b0;
         res_data_o  <= '0;
      end else begin
         if (res_valid_o && res_ready_i) begin
            res_valid_o <= 1'b0;
         end
         if (abort_i) begin
            busy <= 1'b0;
         end else if (start_i) begin
            busy       <= 1'b1;
            step       <= '0;
            dac_code_o <= '0;
         end else if (busy && tick_i) begin
            // MSB first; the first tick sets the MSB trial, each later tick makes one decision.
            step <= step + 1'b1;
            if (step == '0) begin
               dac_code_o <= {1'b1, {(RES_BITS-1){1'b0}}};
            end else begin
               dac_code_o <= next_code;
            end
            if (step == 4'(CONV_TICKS - 1)) begin
               busy        <= 1'b0;
               res_valid_o <= 1'b1;
               res_data_o  <= next_code;
            end
         end
      end
   end

endmodule

// ### acs_ctrl.sv
// Control side of a 14-bit serial successive-approximation converter.
// Assumes the serial pins and the comparator are asynchronous to sys_clk_i.
module acs_ctrl
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                arst_n_i,
   // Serial link pins
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   input  wire logic                din_i,
   output      logic                dout_o,
   output      logic                dout_oe_o,
   output      logic                conversion_strobe_out_o,
   output      logic                conversion_strobe_out_oe_o,
   // Analog front end
   input  wire logic                comp_i,
   output      logic [RES_BITS-1:0] dac_code_o,
   output      logic [2:0]          mux_pos_sel_o,
   output      logic [2:0]          mux_neg_sel_o,
   output      logic                mux_neg_com_o,
   output      logic                mux_open_o,
   output      logic                track_hold_o,
   // Mode status
   output      logic                coding_range_bit_o,
   output      logic                power_down_full_o,
   output      logic                power_down_fast_o,
   output      logic                fifo_ready_o
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Positive channel from the code: single-ended and differential.
   function automatic logic [2:0] pos_channel(input logic h, input logic m,
                                              input logic l);
      return {m, l, h};
   endfunction

   // Straight binary or two's complement for the chosen coding.
   function automatic logic [RES_BITS-1:0] code_word(input logic [RES_BITS-1:0] w,
                                                     input logic unipolar);
      return unipolar ? w : {~w[RES_BITS-1], w[RES_BITS-2:0]};
   endfunction

   // ****************************************************************
   // Synchronisers and edge detection
   // ****************************************************************
   logic [1:0] sclk_s;
   logic [1:0] cs_s;
   logic [1:0] din_s;
   logic [1:0] comp_s;
   logic       sclk_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_low;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_s <= '0;
         cs_s   <= 2'h3;
         din_s  <= '0;
         comp_s <= '0;
         sclk_q <= 1'b0;
      end else begin
         sclk_s <= {sclk_s[0], sclk_i};
         cs_s   <= {cs_s[0], cs_n_i};
         din_s  <= {din_s[0], din_i};
         comp_s <= {comp_s[0], comp_i};
         sclk_q <= sclk_s[1];
      end
   end

   assign cs_low    = ~cs_s[1];
   assign sclk_rise = sclk_s[1] & ~sclk_q;
   assign sclk_fall = ~sclk_s[1] & sclk_q;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   acs_state_t          state;
   logic [BYTE_BITS-1:0] ctrl_shift;
   logic [4:0]          fall_cnt;
   logic [4:0]          next_fall;
   logic                start_bit;
   logic                conv_start;
   logic                conv_tick;
   logic                res_valid;
   logic                res_ready;
   logic [RES_BITS-1:0] res_data;
   logic [$clog2(INT_TICK_CYC)-1:0] div_cnt;
   logic                div_tick;
   acs_mode_t           mode;

   assign next_fall = fall_cnt + 1'b1;
   // Zeros are ignored until a one arrives with chip select low.
   assign start_bit = cs_low & sclk_rise & din_s[1] & (state == ST_IDLE);
   assign conv_start = (state == ST_RECEIVE) & sclk_fall & (next_fall == FALL_HOLD)
                       & ctrl_shift[BIT_MODE_H];

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= ST_IDLE;
         fall_cnt <= '0;
      end else if (!cs_low) begin
         // Raising chip select abandons the byte and any conversion.
         state    <= ST_IDLE;
         fall_cnt <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_bit) begin
                  state    <= ST_RECEIVE;
                  fall_cnt <= '0;
               end
            end
            ST_RECEIVE: begin
               if (sclk_fall) begin
                  fall_cnt <= next_fall;
                  if (next_fall == FALL_HOLD) begin
                     case (acs_mode_t'(ctrl_shift[BIT_MODE_H:BIT_MODE_L]))
                        MODE_EXT_CLK: state <= ST_EXT_CONV;
                        MODE_INT_CLK: state <= ST_INT_CONV;
                        default:      state <= ST_IDLE;
                     endcase
                  end
               end
            end
            ST_EXT_CONV: begin
               // The host must keep clocking until the final edge.
               if (sclk_fall) begin
                  fall_cnt <= next_fall;
                  if (next_fall == FALL_DONE) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_INT_CONV: begin
               if (res_valid && res_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Control byte shift register, MSB first.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_shift <= '0;
      end else if (start_bit) begin
         ctrl_shift <= {{(BYTE_BITS-1){1'b0}}, 1'b1};
      end else if (cs_low && sclk_rise && state == ST_RECEIVE) begin
         ctrl_shift <= {ctrl_shift[BYTE_BITS-2:0], din_s[1]};
      end
   end

   // ****************************************************************
   // Mode and power-down
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode               <= MODE_RST;
         coding_range_bit_o <= 1'b1;
         power_down_full_o  <= 1'b0;
         power_down_fast_o  <= 1'b0;
      end else if (start_bit) begin
         power_down_full_o <= 1'b0;
         power_down_fast_o <= 1'b0;
      end else if (state == ST_RECEIVE && sclk_fall && next_fall == FALL_HOLD) begin
         mode               <= acs_mode_t'(ctrl_shift[BIT_MODE_H:BIT_MODE_L]);
         coding_range_bit_o <= ctrl_shift[BIT_RANGE];
         power_down_full_o  <= (ctrl_shift[BIT_MODE_H:BIT_MODE_L] == MODE_PD_FULL);
         power_down_fast_o  <= (ctrl_shift[BIT_MODE_H:BIT_MODE_L] == MODE_PD_FAST);
      end
   end

   // ****************************************************************
   // Input multiplexer and track/hold
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mux_pos_sel_o <= '0;
         mux_neg_sel_o <= '0;
         mux_neg_com_o <= 1'b1;
      end else if (state == ST_RECEIVE && sclk_fall && next_fall == FALL_MUX) begin
         // Five bits are in: start, channel code and configuration.
         // Bit 0 is the configuration, bits 3:1 the channel code.
         mux_pos_sel_o <= pos_channel(ctrl_shift[3], ctrl_shift[2], ctrl_shift[1]);
         mux_neg_sel_o <= pos_channel(~ctrl_shift[3], ctrl_shift[2], ctrl_shift[1]);
         mux_neg_com_o <= ctrl_shift[0];
      end
   end

   // The selection registers keep the last programmed channel.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mux_open_o   <= 1'b0;
         track_hold_o <= 1'b0;
      end else if (conv_start) begin
         // Acquisition ran over falls 5 to 8.
         mux_open_o   <= 1'b1;
         track_hold_o <= 1'b1;
      end else if (state == ST_IDLE || state == ST_RECEIVE
                   || (state == ST_INT_CONV && res_valid && res_ready)) begin
         // Track resumes in the same cycle as the completion strobe.
         mux_open_o   <= 1'b0;
         track_hold_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Conversion clock and engine
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= '0;
      end else if (state != ST_INT_CONV || div_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   assign div_tick  = (div_cnt == ($clog2(INT_TICK_CYC))'(INT_TICK_CYC - 1));
   assign conv_tick = (state == ST_EXT_CONV) ? sclk_fall
                    : (state == ST_INT_CONV) & div_tick;
   assign res_ready = (state == ST_EXT_CONV) | fifo_ready_o;

   // Fifteen ticks resolve the held sample.
   acs_sar u_sar (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .start_i     (conv_start),
      .abort_i     (~cs_low),
      .tick_i      (conv_tick),
      .comp_i      (comp_s[1]),
      .dac_code_o  (dac_code_o),
      .res_valid_o (res_valid),
      .res_ready_i (res_ready),
      .res_data_o  (res_data)
   );

   // ****************************************************************
   // Result buffer
   // ****************************************************************
   logic                fifo_valid;
   logic                fifo_pop;
   logic [RES_BITS-1:0] fifo_data;
   logic [RES_BITS-1:0] out_shift;
   logic [3:0]          out_cnt;

   assign fifo_pop = fifo_valid & (out_cnt == '0) & (state != ST_EXT_CONV);

   acs_fifo #(
      .WIDTH (RES_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i  (sys_clk_i),
      .arst_n_i   (arst_n_i),
      .wr_valid_i (res_valid & (state == ST_INT_CONV)),
      .wr_ready_o (fifo_ready_o),
      .wr_data_i  (code_word(res_data, coding_range_bit_o)),
      .rd_valid_o (fifo_valid),
      .rd_ready_i (fifo_pop),
      .rd_data_o  (fifo_data)
   );

   // ****************************************************************
   // Serial outputs
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_shift <= '0;
         out_cnt   <= '0;
         dout_o    <= 1'b0;
      end else if (fifo_pop) begin
         out_shift <= fifo_data;
         out_cnt   <= INT_READ_FALLS;
      end else if (cs_low && sclk_fall) begin
         if (state == ST_EXT_CONV && next_fall >= FALL_MSB) begin
            // Each decision leaves on the fall that makes it.
            dout_o <= (next_fall == FALL_MSB && !coding_range_bit_o) ? ~comp_s[1]
                                                                      : comp_s[1];
         end else if (out_cnt == INT_READ_FALLS) begin
            // The first fall after completion leads the MSB by one.
            out_cnt <= out_cnt - 1'b1;
            dout_o  <= 1'b0;
         end else if (out_cnt != '0) begin
            out_cnt   <= out_cnt - 1'b1;
            dout_o    <= out_shift[RES_BITS-1];
            out_shift <= {out_shift[RES_BITS-2:0], 1'b0};
         end else begin
            dout_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conversion_strobe_out_o <= STRB_RST;
      end else if (state == ST_INT_CONV && res_valid && res_ready) begin
         conversion_strobe_out_o <= 1'b1;
      end else if (cs_low && sclk_fall) begin
         if (state == ST_RECEIVE && next_fall == FALL_HOLD) begin
            // High for the two periods before the MSB in external mode.
            conversion_strobe_out_o <= ctrl_shift[BIT_MODE_L];
         end else if (state == ST_EXT_CONV && next_fall == FALL_MSB) begin
            conversion_strobe_out_o <= 1'b0;
         end
      end
   end

   // A fresh byte is expected before every conversion.
   assign dout_oe_o                  = cs_low;
   assign conversion_strobe_out_oe_o = cs_low | (mode == MODE_INT_CLK);

endmodule

// ### acs_ctrl_assertions.sv
// Checker of link edge timing, strobe shape and track/hold order.
// Assumes a link clock far slower than sys_clk_i.
module acs_ctrl_assertions
   import acs_pkg::*;
(
   // Watched ports
   input wire logic       sys_clk_i,
   input wire logic       arst_n_i,
   input wire logic       sclk_i,
   input wire logic       cs_n_i,
   input wire logic       dout_o,
   input wire logic       conversion_strobe_out_o,
   input wire logic       track_hold_o,
   input wire logic       mux_open_o,
   input wire logic [2:0] mux_pos_sel_o,
   input wire logic       power_down_full_o,
   input wire logic       power_down_fast_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0]  sh;
   logic [2:0]  nf;
   logic [11:0] hc;
   wire         fr = |(sh[5:1] & ~sh[4:0]);
   wire         st = conversion_strobe_out_o;
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
      if (!arst_n_i) sh <= 6'h0;
      else sh <= {sh[4:0], sclk_i};
   // Link falls counted while the strobe is high and the sample is held.
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
      if (!arst_n_i) nf <= 3'h0;
      else if (!st || !track_hold_o) nf <= 3'h0;
      else if (sh[1] && !sh[0] && nf != 3'h7) nf <= nf + 3'h1;
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
      if (!arst_n_i) hc <= 12'h0;
      else if (!track_hold_o) hc <= 12'h0;
      else if (hc != 12'hfff) hc <= hc + 12'h1;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_dout_edge; !cs_n_i && $changed(dout_o) |-> fr; endproperty
   a_dout_edge: assert property (p_dout_edge) else $error("dout off edge");
   property p_strb_fall; !cs_n_i && $fell(st) |-> fr; endproperty
   a_strb_fall: assert property (p_strb_fall) else $error("strobe off edge");
   property p_strb_two; $fell(st) && $past(track_hold_o) |-> nf == 3'h2; endproperty
   a_strb_two: assert property (p_strb_two) else $error("strobe width");
   property p_hold; $rose(track_hold_o) |-> $rose(mux_open_o) && fr; endproperty
   a_hold: assert property (p_hold) else $error("hold without open");
   property p_track; $fell(track_hold_o) |-> !mux_open_o; endproperty
   a_track: assert property (p_track) else $error("mux not restored");
   property p_strb_rise;
      $rose(st) && !power_down_full_o && !power_down_fast_o |-> $changed(track_hold_o);
   endproperty
   a_strb_rise: assert property (p_strb_rise) else $error("strobe rise");
   property p_conv_len;
      $rose(st) && $fell(track_hold_o) |-> hc >= 14 * INT_TICK_CYC && hc <= 16 * INT_TICK_CYC;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length");
   property p_mux_edge; $changed(mux_pos_sel_o) |-> fr; endproperty
   a_mux_edge: assert property (p_mux_edge) else $error("mux off edge");
   property p_pd_excl; !(power_down_full_o && power_down_fast_o); endproperty
   a_pd_excl: assert property (p_pd_excl) else $error("two power modes");
   c_ext: cover property ($fell(st) && $past(track_hold_o));
   c_int: cover property ($rose(st) && $fell(track_hold_o));
   c_pd: cover property ($rose(power_down_fast_o));
endmodule
bind acs_ctrl acs_ctrl_assertions u_acs_ctrl_assertions (.*);

// ### acs_host.sv
// Host model: link master clocking bytes in and results out.
// Assumes an 80 ns link period, eight bench clocks.
module acs_host (
   // Bench clock
   input  wire logic sys_clk_i,
   // Link pins
   output      logic sclk_o,
   output      logic cs_n_o,
   output      logic din_o,
   input  wire logic dout_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] tx = 24'h0;
   logic [23:0] rx = 24'h0;
   event        got;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   // Results are taken on rising edges, since the device shifts on falls.
   task automatic xfer(input int n, input logic fin);
      cs_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         din_o = tx[23];
         tx = {tx[22:0], 1'b0};
         repeat (4) @(negedge sys_clk_i);
         sclk_o = 1'b1;
         rx = {rx[22:0], dout_i};
         repeat (4) @(negedge sys_clk_i);
         sclk_o = 1'b0;
      end
      if (fin) -> got;
   endtask
   task automatic idle();
      repeat (4) @(negedge sys_clk_i);
      cs_n_o = 1'b1;
      din_o = ~din_o;
   endtask
endmodule

// ### acs_ctrl_tb.sv
// Bench of the converter control block driven by the host model.
// Assumes a 10 ns bench clock; words arrive through the host's event.
module acs_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk_i, arst_n_i, comp_i;
   logic        sclk, cs_n, din, dout, dout_oe, strb, strb_oe, fready;
   logic        ncom, mopen, hold, rng_o, pd_full, pd_fast;
   logic [2:0]  pos, neg;
   logic [13:0] e;
   logic [31:0] lf;
   logic [13:0] q[$];
   int          err_count, total_checks;
   acs_ctrl u_acs_ctrl (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .conversion_strobe_out_o(strb),
      .conversion_strobe_out_oe_o(strb_oe), .comp_i(comp_i), .dac_code_o(),
      .mux_pos_sel_o(pos), .mux_neg_sel_o(neg), .mux_neg_com_o(ncom),
      .mux_open_o(mopen), .track_hold_o(hold), .coding_range_bit_o(rng_o),
      .power_down_full_o(pd_full), .power_down_fast_o(pd_fast), .fifo_ready_o(fready));
   acs_host u_acs_host (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
      .din_o(din), .dout_i(dout_oe ? dout : ~dout));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(u_acs_host.got) chk(u_acs_host.rx[13:0], q.pop_front());
   initial begin
      logic [7:0] b;
      logic [1:0] md;
      int         k;
      err_count = 0;
      total_checks = 0;
      lf = 32'haf08;
      comp_i = 1'b0;
      arst_n_i = 1'b0;
      repeat (10) @(negedge sys_clk_i);
      arst_n_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      for (int i = 0; i < 16; i++) begin
         lf = nxt(lf);
         md = ~(i[1:0] ^ i[3:2]);
         b = {1'b1, i[2:0], i[3], lf[1], md};
         comp_i = lf[0];
         u_acs_host.tx = {b, 16'h0} >> (i % 4);
         u_acs_host.xfer(5 + i % 4, 1'b0);
         repeat (4) @(negedge sys_clk_i);
         e = {7'h0, b[5], b[4], b[6], b[3], b[3] ? 3'h0 : {b[5], b[4], ~b[6]}};
         chk({3'h0, mopen, hold, pd_full, pd_fast, pos, ncom,
              ncom ? 3'h0 : neg}, e);
         // The channel map above takes the code bits in the order M, L, H.
         u_acs_host.xfer(3, 1'b0);
         repeat (4) @(negedge sys_clk_i);
         e = md[1] ? {8'h0, 2'h3, md[0], b[2], 2'h0} : {12'h0, ~md[0], md[0]};
         chk(md[1] ? {8'h0, hold, mopen, strb, rng_o, pd_full, pd_fast}
                   : {12'h0, pd_full, pd_fast}, e);
         for (k = 0; k < 2000 && md == 2'h2 && strb !== 1'b1; k++) @(negedge sys_clk_i);
         if (k == 2000) begin
            err_count++;
            end_of_test();
         end
         if (md[1]) begin
            q.push_back({comp_i ^ ~b[2], {13{comp_i}}});
            u_acs_host.xfer(16, 1'b1);
         end
         u_acs_host.idle();
         repeat (8) @(negedge sys_clk_i);
         chk({9'h0, fready, md[1] & hold, md[1] & mopen, dout_oe, md[1] & strb_oe},
             {9'h0, 1'b1, 3'h0, md == 2'h2});
         $display("test %0d done", i);
      end
      end_of_test();
   end
endmodule
